// ===== rtl/core_interrupt_control.sv
/*
  Core interrupt control: enables, sticky flags and the CPU request, with an
  AXI4-Lite slave for the registers.
  Assumes timer0 and PWM events are one-cycle pulses on CLK_SYS, while the
  external pin and the pin-change pins are asynchronous.
*/
`default_nettype none

module core_interrupt_control #(
  parameter int PINS = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic EXT_PIN,
  input wire logic [PINS-1:0] PIN_CHANGE_PINS,
  input wire logic TIMER0_WRAP,
  input wire logic PWM1_TIMEBASE,
  input wire logic PWM2_TIMEBASE,
  input wire logic PWM1_SHUTDOWN,
  input wire logic PWM2_SHUTDOWN,
  output logic CPU_IRQ
);
  import irq_ctrl_pkg::*;

  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff, irq_ff;
  logic [7:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic w_lane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [4:0] ctrl_en_ff;
  logic t0_flag_ff, ext_flag_ff;
  logic [PINS-1:0] pin_flags_ff;
  logic [7:0] pwm_en_ff, pwm_stat_ff;

  // Pins pass two flops before any edge logic looks at them.
  edge_evt_if #(.W(PINS + 1)) evt ();
  event_sync #(.W(PINS + 1)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .din({EXT_PIN, PIN_CHANGE_PINS}),
    .evt(evt)
  );

  wire ext_rise = evt.rise[PINS];
  wire [PINS-1:0] pin_change = evt.change[PINS-1:0];

  // Write side: address and data are caught separately, in either order.
  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire wr_do = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire [7:0] wr_word = {aw_addr_ff[7:2], 2'h0};
  wire wr_ctrl = wr_do & w_lane_ff & (wr_word == OFS_INT_CTRL);
  wire wr_pwm_en = wr_do & w_lane_ff & (wr_word == OFS_PWM_EN);
  wire wr_pins = wr_do & w_lane_ff & (wr_word == OFS_PIN_FLAGS);
  wire wr_pwm_st = wr_do & w_lane_ff & (wr_word == OFS_PWM_STAT);
  wire wr_mapped = (wr_word == OFS_INT_CTRL) | (wr_word == OFS_PWM_EN) |
                   (wr_word == OFS_PIN_FLAGS) | (wr_word == OFS_PWM_STAT);

  assign AWREADY = ~aw_hold_ff & ~bvalid_ff;
  assign WREADY = ~w_hold_ff & ~bvalid_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;

  // A new write is held off until the previous answer has been taken.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
      end
      else if (wr_do)
        aw_hold_ff <= 1'b0;
      if (w_take)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= WDATA[7:0];
        w_lane_ff <= WSTRB[0];
      end
      else if (wr_do)
        w_hold_ff <= 1'b0;
      if (wr_do)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY)
        bvalid_ff <= 1'b0;
    end
  end

  // The summary flag has no storage of its own, so software cannot write it.
  wire pc_summary = |pin_flags_ff;
  wire [7:0] ctrl_view = {ctrl_en_ff, t0_flag_ff, ext_flag_ff, pc_summary};
  wire [7:0] pwm_evt = {2'h0, PWM2_TIMEBASE, PWM1_TIMEBASE, 2'h0, PWM2_SHUTDOWN, PWM1_SHUTDOWN};

  // Flag next values: an event in the clearing cycle wins over the clear.
  wire nxt_t0_flag = TIMER0_WRAP | (wr_ctrl ? w_data_ff[BIT_T0_FLAG] : t0_flag_ff);
  wire nxt_ext_flag = ext_rise | (wr_ctrl ? w_data_ff[BIT_EXT_FLAG] : ext_flag_ff);
  wire [PINS-1:0] pin_clr = wr_pins ? w_data_ff[PINS-1:0] : '0;
  wire [PINS-1:0] nxt_pin_flags = pin_change | (pin_flags_ff & ~pin_clr);
  wire [7:0] pwm_clr = wr_pwm_st ? w_data_ff : 8'h00;
  wire [7:0] nxt_pwm_stat = (pwm_evt | (pwm_stat_ff & ~pwm_clr)) & PWM_IMPL_MASK;

  // Request logic; peripheral sources pass only under the peripheral enable.
  wire core_req = (t0_flag_ff & ctrl_en_ff[BIT_T0_EN - 3]) |
                  (ext_flag_ff & ctrl_en_ff[BIT_EXT_EN - 3]) |
                  (pc_summary & ctrl_en_ff[BIT_PC_EN - 3]);
  wire periph_req = |(pwm_stat_ff & pwm_en_ff);
  wire nxt_irq = ctrl_en_ff[BIT_GIE - 3] &
                 (core_req | (ctrl_en_ff[BIT_PERIPHERAL_IRQ_ENABLE - 3] & periph_req));

  // Register state; writes use byte lane 0 only, as all registers are 8 bits.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl_en_ff <= RST_INT_CTRL[7:3];
      t0_flag_ff <= RST_INT_CTRL[BIT_T0_FLAG];
      ext_flag_ff <= RST_INT_CTRL[BIT_EXT_FLAG];
      pin_flags_ff <= RST_PIN_FLAGS[PINS-1:0];
      pwm_en_ff <= RST_PWM_EN;
      pwm_stat_ff <= RST_PWM_STAT;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_en_ff <= w_data_ff[7:3];
      if (wr_pwm_en)
        pwm_en_ff <= w_data_ff & PWM_IMPL_MASK;
      t0_flag_ff <= nxt_t0_flag;
      ext_flag_ff <= nxt_ext_flag;
      pin_flags_ff <= nxt_pin_flags;
      pwm_stat_ff <= nxt_pwm_stat;
      irq_ff <= nxt_irq;
    end
  end

  assign CPU_IRQ = irq_ff;

  // Read side: one answer in flight; unmapped words read zero with SLVERR.
  wire ar_take = ARVALID & ARREADY;
  wire [7:0] rd_word = {ARADDR[7:2], 2'h0};
  wire rd_ctrl = rd_word == OFS_INT_CTRL;
  wire rd_pwm_en = rd_word == OFS_PWM_EN;
  wire rd_pins = rd_word == OFS_PIN_FLAGS;
  wire rd_pwm_st = rd_word == OFS_PWM_STAT;
  wire rd_mapped = rd_ctrl | rd_pwm_en | rd_pins | rd_pwm_st;
  wire [7:0] rd_byte = ({8{rd_ctrl}} & ctrl_view) | ({8{rd_pwm_en}} & pwm_en_ff) |
                       ({8{rd_pins}} & 8'(pin_flags_ff)) | ({8{rd_pwm_st}} & pwm_stat_ff);

  assign ARREADY = ~rvalid_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RREADY)
      rvalid_ff <= 1'b0;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_ext_flag_set: assert property (ext_rise |=> ext_flag_ff)
    else $error("External pin event did not set its flag.");
  a_pin_set_wins: assert property ((|(pin_change & pin_clr)) |=> (|pin_flags_ff))
    else $error("Pin change lost against a clear.");
  a_summary_tracks: assert property (ctrl_view[BIT_PC_SUM] == (|pin_flags_ff))
    else $error("Summary flag differs from the pin flags.");
  a_summary_ro: assert property (
      wr_ctrl && pin_flags_ff == '0 && pin_change == '0 |=> !ctrl_view[BIT_PC_SUM])
    else $error("Summary flag changed by a control write.");
  a_t0_flag_set: assert property (TIMER0_WRAP |=> t0_flag_ff)
    else $error("Timer0 wrap did not set its flag.");
  a_irq_core: assert property (
      t0_flag_ff && ctrl_en_ff[BIT_T0_EN - 3] && ctrl_en_ff[BIT_GIE - 3] && !$past(RST)
      |=> CPU_IRQ)
    else $error("Enabled timer0 flag raised no request.");
  a_irq_needs_gie: assert property (CPU_IRQ |-> $past(ctrl_en_ff[BIT_GIE - 3]))
    else $error("Request without the global enable.");
  a_periph_gated: assert property (
      CPU_IRQ && !$past(core_req) |-> $past(ctrl_en_ff[BIT_PERIPHERAL_IRQ_ENABLE - 3]) && $past(periph_req))
    else $error("Peripheral request without the peripheral enable.");
  a_read_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read answer dropped before it was taken.");
  a_ctrl_reset: assert property ($fell(RST) |-> ctrl_view == RST_INT_CTRL)
    else $error("Control register not clear after reset.");

endmodule

`default_nettype wire

// ===== include/irq_ctrl_pkg.sv
/*
  Shared constants of the core interrupt control block: register offsets,
  field positions, reset values and AXI4-Lite answer codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`default_nettype none

package irq_ctrl_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] OFS_INT_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWM_EN = 8'h04;
  localparam logic [7:0] OFS_PIN_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PWM_STAT = 8'h0c;

  // Field positions of the interrupt control register.
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_T0_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_PC_EN = 3;
  localparam int BIT_T0_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_PC_SUM = 0;

  // Field positions shared by the PWM enable and PWM status registers.
  localparam int BIT_PWM2_TB = 5;
  localparam int BIT_PWM1_TB = 4;
  localparam int BIT_PWM2_SD = 1;
  localparam int BIT_PWM1_SD = 0;
  localparam logic [7:0] PWM_IMPL_MASK = 8'h33;

  // Values after reset.
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PWM_EN = 8'h00;
  localparam logic [7:0] RST_PIN_FLAGS = 8'h00;
  localparam logic [7:0] RST_PWM_STAT = 8'h00;

  // AXI4-Lite answer codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ===== include/edge_evt_if.sv
/*
  Carrier between the input synchroniser and the interrupt control logic.
  Holds one-cycle rise and change pulses, one bit per synchronised input.
*/
`default_nettype none

interface edge_evt_if #(parameter int W = 9);
  logic [W-1:0] rise;
  logic [W-1:0] change;
  modport src (output rise, output change);
  modport dst (input rise, input change);
endinterface

`default_nettype wire

// ===== rtl/event_sync.sv
/*
  Two-flop synchroniser with an edge detector for a group of pins.
  Assumes the pins are asynchronous to clk; pulses last one clock.
*/
`default_nettype none

module event_sync #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  edge_evt_if.src evt
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;
  logic [2:0] arm_ff;

  // The first stage feeds only the second; edges are taken after it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
      arm_ff <= '0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      arm_ff <= {arm_ff[1:0], 1'b1};
    end
  end

  // Rise and any-edge pulses, held off until the pipe holds real pin samples.
  // Without this, a pin held high through reset would look like a fresh edge.
  // Limitation: a genuine edge in the first cycle after reset is lost.
  assign evt.rise = sync_ff & ~last_ff & {W{arm_ff[2]}};
  assign evt.change = (sync_ff ^ last_ff) & {W{arm_ff[2]}};

endmodule

`default_nettype wire

// ===== testbench/cpu_core_model.sv
/*
  Behavioural model of the CPU core that takes interrupt requests.
  Assumes a level request on the system clock; counts interrupt entries.
*/
`default_nettype none

module cpu_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_req,
  output logic [7:0] entries_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;

  // One entry per rise of the level, as a core would vector only once.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_ff <= 1'b0;
      entries_ff <= 8'h00;
    end
    else
    begin
      prev_ff <= irq_req;
      if (irq_req && !prev_ff)
        entries_ff <= entries_ff + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ===== testbench/core_interrupt_control_tb.sv
/*
  Self-checking bench for the core interrupt control block.
  Assumes the package and design files are compiled first.
*/
`default_nettype none

module core_interrupt_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;
    logic [1:0] r; logic i;} row_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic ext_pin = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [4:0] ev = 5'h00; // Timer0, then PWM events.
  logic awready, wready, bvalid, arready, rvalid, cpu_irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, q;
  logic [7:0] entries;
  int err_count = 0;
  int samples_checked = 0;
  row_type rows [6] = '{
    '{OFS_INT_CTRL, 8'hff, 8'hfe, RESP_OKAY, 1'b1},
    '{OFS_INT_CTRL, 8'h06, 8'h06, RESP_OKAY, 1'b0},
    '{OFS_INT_CTRL, 8'h00, 8'h00, RESP_OKAY, 1'b0},
    '{OFS_PWM_EN, 8'hff, 8'h33, RESP_OKAY, 1'b0},
    '{8'h10, 8'hff, 8'h00, RESP_SLVERR, 1'b0},
    '{OFS_PWM_EN, 8'h00, 8'h00, RESP_OKAY, 1'b0}};

  // Half period of the 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  core_interrupt_control dut_u (.CLK_SYS(clk_sys), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EXT_PIN(ext_pin), .PIN_CHANGE_PINS(pins), .TIMER0_WRAP(ev[0]),
    .PWM1_TIMEBASE(ev[1]), .PWM2_TIMEBASE(ev[2]),
    .PWM1_SHUTDOWN(ev[3]), .PWM2_SHUTDOWN(ev[4]), .CPU_IRQ(cpu_irq));

  cpu_core_model cpu_u (.clk(clk_sys), .rst(rst), .irq_req(cpu_irq),
    .entries_ff(entries));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Handshakes are judged at the falling edge, when ready is settled,
  // and released by the rising edge that took them. The answer ready
  // stays high once raised, though every call drives it high again.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w, b;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk_sys);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v)
    begin
      @(negedge clk_sys);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ar)
        arvalid <= 1'b0;
    end
  endtask

  // Every register must read zero after a reset.
  task automatic reset_reads;
    logic [31:0] v;
    logic [1:0] s;
    for (int k = 0; k < 4; k++)
    begin
      rd(8'(k * 4), v, s);
      chk("reset", v, 32'h0);
    end
  endtask

  task automatic irqchk(input logic e);
    @(negedge clk_sys);
    chk("irq", {31'h0, cpu_irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask

  task automatic ev_pulse(input logic [4:0] m);
    ev <= m;
    @(posedge clk_sys);
    ev <= 5'h00;
    @(posedge clk_sys);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The run needs well under a thousand cycles; this only cuts a hang.
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end

  // Reset values, the table, then event scenarios.
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    reset_reads();
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d, rsp);
      chk("bresp", 32'(rsp), 32'(rows[k].r));
      rd(rows[k].a, q, rsp);
      chk("rdata", q, {24'h0, rows[k].q});
      chk("rresp", 32'(rsp), 32'(rows[k].r));
      irqchk(rows[k].i);
    end
    ev_pulse(5'h01);
    rd(OFS_INT_CTRL, q, rsp);
    chk("t0flag", q, 32'h04);
    irqchk(1'b0);
    wr(OFS_INT_CTRL, 8'ha4, rsp);
    irqchk(1'b1);
    wr(OFS_INT_CTRL, 8'h80, rsp);
    irqchk(1'b0);
    ext_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(OFS_INT_CTRL, q, rsp);
    chk("extflag", q, 32'h82);
    // Stale flags are cleared before any later enable.
    wr(OFS_INT_CTRL, 8'h00, rsp);
    rd(OFS_INT_CTRL, q, rsp);
    chk("extclr", q, 32'h0);
    pins <= 8'h24;
    repeat (5) @(posedge clk_sys);
    rd(OFS_PIN_FLAGS, q, rsp);
    chk("pinflags", q, 32'h24);
    wr(OFS_INT_CTRL, 8'h88, rsp);
    rd(OFS_INT_CTRL, q, rsp);
    chk("sumkept", q, 32'h89);
    irqchk(1'b1);
    wr(OFS_PIN_FLAGS, 8'h04, rsp);
    rd(OFS_INT_CTRL, q, rsp);
    chk("sumpart", q, 32'h89);
    wr(OFS_PIN_FLAGS, 8'h20, rsp);
    rd(OFS_INT_CTRL, q, rsp);
    chk("sumclr", q, 32'h88);
    irqchk(1'b0);
    wr(OFS_INT_CTRL, 8'h00, rsp);
    // A pin edge lands in the very cycle its flag is cleared: the edge wins.
    pins <= 8'h25;
    repeat (5) @(posedge clk_sys);
    pins <= 8'h24;
    @(posedge clk_sys);
    wr(OFS_PIN_FLAGS, 8'h01, rsp);
    rd(OFS_PIN_FLAGS, q, rsp);
    chk("pinwins", q, 32'h01);
    wr(OFS_PIN_FLAGS, 8'h01, rsp);
    ev_pulse(5'h1e);
    rd(OFS_PWM_STAT, q, rsp);
    chk("pwmstat", q, 32'h33);
    wr(OFS_PWM_EN, 8'h33, rsp);
    wr(OFS_INT_CTRL, 8'h80, rsp);
    irqchk(1'b0);
    wr(OFS_INT_CTRL, 8'hc0, rsp);
    irqchk(1'b1);
    wr(OFS_PWM_STAT, 8'h33, rsp);
    irqchk(1'b0);
    chk("entries", 32'(entries), 32'h4);
    // Mid-run reset with the PWM flags, their enables, GIE and PIE, and pins 2, 5 and EXT_PIN up.
    ev_pulse(5'h1e);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    reset_reads();
    irqchk(1'b0);
    chk("entries0", 32'(entries), 32'h0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
